// file: design/mtu_top.v
// Multi timer unit: four PWM/capture subsystems behind an AXI4-Lite slave
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`include "mtu_defines.vh"
module mtu_top #(
  parameter ADDR_W = 12
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write
  input wire [ADDR_W-1:0] awaddr,
  input wire awvalid,
  output wire awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  // AXI4-Lite read
  input wire [ADDR_W-1:0] araddr,
  input wire arvalid,
  output wire arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  // Timer pins
  input wire [7:0] timer_pin_in,
  output wire [7:0] timer_pin_out,
  output wire [7:0] timer_pin_oe_n,
  // Debug and interrupts
  input wire debug_halt,
  output reg [3:0] irq
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [15:0] f_merge;
    input [15:0] old;
    input [15:0] wd;
    input [1:0] strb;
    begin
      f_merge = {strb[1] ? wd[15:8] : old[15:8], strb[0] ? wd[7:0] : old[7:0]};
    end
  endfunction

  // Capture event for a given edge code
  function f_cap;
    input [2:0] code;
    input r;
    input f;
    begin
      f_cap = code[2] ? (r | f) : (code[0] ? f : r);
    end
  endfunction

  // Counter reset for a given edge code
  function f_rst;
    input [2:0] code;
    input r;
    input f;
    begin
      if (code[2]) begin
        f_rst = (code[0] & r) | (code[1] & f);
      end else begin
        f_rst = code[1] & (code[0] ? f : r);
      end
    end
  endfunction

  // ----------------------------------------
  // Shared registers
  // ----------------------------------------
  reg [15:0] mode_reg;
  reg [15:0] pin_control1_reg;
  reg [15:0] pin_control2_reg;
  reg [15:0] irq_enable_reg;
  reg [15:0] pending_reg;
  reg [15:0] prescale1_reg;
  reg [15:0] prescale2_reg;
  reg [15:0] pending_next;

  wire [31:0] pin_ctl_all = {pin_control2_reg, pin_control1_reg};
  wire [31:0] prescale_all = {prescale2_reg, prescale1_reg};
  wire [15:0] pend_set;
  wire [15:0] lp_nib;
  wire [63:0] cnt_all;
  wire [63:0] per_all;
  wire [63:0] dty_all;
  wire [7:0] pin_rise;
  wire [7:0] pin_fall;

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  // Address and data taken together; one write outstanding
  wire wr_hs = awvalid & wvalid & ~bvalid;
  wire [9:0] wr_idx = awaddr[11:2];
  wire [9:0] rd_idx = araddr[11:2];
  wire [15:0] wd = wdata[15:0];
  wire [1:0] ws = wstrb[1:0];
  reg wr_hit;
  reg rd_hit;
  reg [15:0] rd_val;

  assign awready = wr_hs;
  assign wready = wr_hs;
  assign arready = ~rvalid;

  always @* begin
    case (wr_idx)
      `MTU_IDX_MODE, `MTU_IDX_PCTL1, `MTU_IDX_PCTL2, `MTU_IDX_IRQEN, `MTU_IDX_PEND,
      `MTU_IDX_PSC1, `MTU_IDX_PSC2, `MTU_IDX_CNT1, `MTU_IDX_PER1, `MTU_IDX_DTY1,
      `MTU_IDX_CNT2, `MTU_IDX_PER2, `MTU_IDX_DTY2, `MTU_IDX_CNT3, `MTU_IDX_PER3,
      `MTU_IDX_DTY3, `MTU_IDX_CNT4, `MTU_IDX_PER4, `MTU_IDX_DTY4: begin
        wr_hit = 1'b1;
      end
      default: begin
        wr_hit = 1'b0;
      end
    endcase
  end

  always @* begin
    rd_hit = 1'b1;
    case (rd_idx)
      `MTU_IDX_MODE: rd_val = mode_reg;
      `MTU_IDX_PCTL1: rd_val = pin_control1_reg;
      `MTU_IDX_PCTL2: rd_val = pin_control2_reg;
      `MTU_IDX_IRQEN: rd_val = irq_enable_reg;
      `MTU_IDX_PEND: rd_val = pending_reg;
      `MTU_IDX_PSC1: rd_val = prescale1_reg;
      `MTU_IDX_PSC2: rd_val = prescale2_reg;
      `MTU_IDX_CNT1: rd_val = cnt_all[15:0];
      `MTU_IDX_PER1: rd_val = per_all[15:0];
      `MTU_IDX_DTY1: rd_val = dty_all[15:0];
      `MTU_IDX_CNT2: rd_val = cnt_all[31:16];
      `MTU_IDX_PER2: rd_val = per_all[31:16];
      `MTU_IDX_DTY2: rd_val = dty_all[31:16];
      `MTU_IDX_CNT3: rd_val = cnt_all[47:32];
      `MTU_IDX_PER3: rd_val = per_all[47:32];
      `MTU_IDX_DTY3: rd_val = dty_all[47:32];
      `MTU_IDX_CNT4: rd_val = cnt_all[63:48];
      `MTU_IDX_PER4: rd_val = per_all[63:48];
      `MTU_IDX_DTY4: rd_val = dty_all[63:48];
      default: begin
        rd_val = `MTU_RST16;
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `MTU_RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= `MTU_RESP_OKAY;
      rdata <= 32'h00000000;
    end else begin
      if (wr_hs) begin
        bvalid <= 1'b1;
        bresp <= wr_hit ? `MTU_RESP_OKAY : `MTU_RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
      if (arvalid && !rvalid) begin
        rvalid <= 1'b1;
        rresp <= rd_hit ? `MTU_RESP_OKAY : `MTU_RESP_SLVERR;
        rdata <= {16'h0000, rd_val};
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Shared register writes and pending bits
  // ----------------------------------------
  always @* begin
    pending_next = pending_reg;
    if (wr_hs && wr_idx == `MTU_IDX_PEND) begin
      pending_next = pending_reg & ~(wd & {{8{ws[1]}}, {8{ws[0]}}} & ~lp_nib);
    end
    pending_next = pending_next | pend_set;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= `MTU_RST16;
      pin_control1_reg <= `MTU_RST16;
      pin_control2_reg <= `MTU_RST16;
      irq_enable_reg <= `MTU_RST16;
      prescale1_reg <= `MTU_RST16;
      prescale2_reg <= `MTU_RST16;
      pending_reg <= `MTU_RST16;
      irq <= 4'h0;
    end else begin
      if (wr_hs && wr_idx == `MTU_IDX_MODE) mode_reg <= f_merge(mode_reg, wd, ws);
      if (wr_hs && wr_idx == `MTU_IDX_PCTL1) pin_control1_reg <= f_merge(pin_control1_reg, wd, ws);
      if (wr_hs && wr_idx == `MTU_IDX_PCTL2) pin_control2_reg <= f_merge(pin_control2_reg, wd, ws);
      if (wr_hs && wr_idx == `MTU_IDX_IRQEN) irq_enable_reg <= f_merge(irq_enable_reg, wd, ws);
      if (wr_hs && wr_idx == `MTU_IDX_PSC1) prescale1_reg <= f_merge(prescale1_reg, wd, ws);
      if (wr_hs && wr_idx == `MTU_IDX_PSC2) prescale2_reg <= f_merge(prescale2_reg, wd, ws);
      pending_reg <= pending_next;
      irq[0] <= |(pending_reg[3:0] & irq_enable_reg[3:0]);
      irq[1] <= |(pending_reg[7:4] & irq_enable_reg[7:4]);
      irq[2] <= |(pending_reg[11:8] & irq_enable_reg[11:8]);
      irq[3] <= |(pending_reg[15:12] & irq_enable_reg[15:12]);
    end
  end

  mtu_pin_sync #(
    .WIDTH(8)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(timer_pin_in),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // ----------------------------------------
  // Timer subsystems
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sub
      wire [9:0] idx_cnt = (gi == 0) ? `MTU_IDX_CNT1 : (gi == 1) ? `MTU_IDX_CNT2 :
                           (gi == 2) ? `MTU_IDX_CNT3 : `MTU_IDX_CNT4;
      wire [9:0] idx_per = (gi == 0) ? `MTU_IDX_PER1 : (gi == 1) ? `MTU_IDX_PER2 :
                           (gi == 2) ? `MTU_IDX_PER3 : `MTU_IDX_PER4;
      wire [9:0] idx_dty = (gi == 0) ? `MTU_IDX_DTY1 : (gi == 1) ? `MTU_IDX_DTY2 :
                           (gi == 2) ? `MTU_IDX_DTY3 : `MTU_IDX_DTY4;
      wire [1:0] smode = mode_reg[4*gi+3:4*gi+2];
      wire run0 = mode_reg[4*gi];
      wire run1 = mode_reg[4*gi+1];
      wire [7:0] pctl = pin_ctl_all[8*gi+7:8*gi];
      wire [7:0] pcmp = prescale_all[8*gi+7:8*gi];
      wire lp = (smode == `MTU_MODE_LP);
      wire dual = (smode == `MTU_MODE_DUAL8);
      wire wide = (smode == `MTU_MODE_PWM16);
      wire capm = (smode == `MTU_MODE_CAP);
      // upper run bit runs the high half in dual mode only
      wire run_lo = run0 & ~lp;
      wire run_hi = run1 & dual;
      // prescaler runs while either half runs
      wire psc_on = run_lo | run_hi;
      // halt and low power stop all counting
      wire go = ~debug_halt & ~lp;

      reg [7:0] psc_reg;
      reg [15:0] cnt_reg;
      reg [15:0] per_wr_reg;
      reg [15:0] dty_wr_reg;
      reg [15:0] per_act_reg;
      reg [15:0] dty_act_reg;
      reg [1:0] state_reg;
      reg [1:0] pin_reg;
      reg [1:0] oe_n_reg;

      wire tick = psc_on & go & (psc_reg == pcmp);
      wire tick_lo = tick & run_lo;
      wire tick_hi = tick & run_hi;

      // captures armed by lower run bit
      wire cap_en = capm & run0 & ~debug_halt;
      wire cap0 = cap_en & f_cap(pctl[2:0], pin_rise[2*gi], pin_fall[2*gi]);
      wire cap1 = cap_en & f_cap(pctl[6:4], pin_rise[2*gi+1], pin_fall[2*gi+1]);
      wire crst = cap_en & (f_rst(pctl[2:0], pin_rise[2*gi], pin_fall[2*gi]) |
                            f_rst(pctl[6:4], pin_rise[2*gi+1], pin_fall[2*gi+1]));

      wire lo_pm = cnt_reg[7:0] == per_act_reg[7:0];
      wire hi_pm = cnt_reg[15:8] == per_act_reg[15:8];
      wire w_pm = cnt_reg == per_act_reg;
      wire lo_dm = cnt_reg[7:0] == dty_act_reg[7:0];
      wire hi_dm = cnt_reg[15:8] == dty_act_reg[15:8];
      wire w_dm = cnt_reg == dty_act_reg;
      // preset above period rolls over naturally
      wire [7:0] lo_nx = lo_pm ? `MTU_RST8 : cnt_reg[7:0] + 8'h01;
      wire [7:0] hi_nx = hi_pm ? `MTU_RST8 : cnt_reg[15:8] + 8'h01;
      wire [15:0] w_nx = (w_pm & ~capm) ? `MTU_RST16 : cnt_reg + 16'h0001;
      wire ovf = capm & tick_lo & (cnt_reg == `MTU_CNT_MAX) & ~crst;

      // Channel views: low byte or full word for channel 0, high byte for channel 1
      wire c0_dm = dual ? lo_dm : w_dm;
      wire c0_zero = dual ? (dty_act_reg[7:0] == `MTU_RST8) : (dty_act_reg == `MTU_RST16);
      wire c0_up = dual ? ((cnt_reg[7:0] == `MTU_RST8) & ~lo_pm) : ((cnt_reg == `MTU_RST16) & ~w_pm);
      wire c1_zero = dty_act_reg[15:8] == `MTU_RST8;
      wire c1_up = (cnt_reg[15:8] == `MTU_RST8) & ~hi_pm;
      // load at period match or while stopped
      wire ld_lo = ~run_lo | (tick_lo & (dual ? lo_pm : w_pm));
      wire ld_hi = dual ? (~run_hi | (tick_hi & hi_pm)) : ld_lo;

      always @(posedge aclk) begin
        if (!aresetn) begin
          psc_reg <= `MTU_RST8;
        end else if (go) begin
          // prescaler resets once both halves stop
          if (!psc_on || tick || crst) begin
            psc_reg <= `MTU_RST8;
          end else begin
            psc_reg <= psc_reg + 8'h01;
          end
        end
      end

      always @(posedge aclk) begin
        if (!aresetn) begin
          cnt_reg <= `MTU_RST16;
        // preset only while both halves stopped
        end else if (wr_hs && wr_idx == idx_cnt && !lp && !run0 && !run1) begin
          cnt_reg <= f_merge(cnt_reg, wd, ws);
        end else if (crst) begin
          cnt_reg <= `MTU_RST16;
        end else if (dual) begin
          if (tick_lo) cnt_reg[7:0] <= lo_nx;
          if (tick_hi) cnt_reg[15:8] <= hi_nx;
        end else if (tick_lo) begin
          cnt_reg <= w_nx;
        end
      end

      always @(posedge aclk) begin
        if (!aresetn) begin
          per_wr_reg <= `MTU_RST16;
          dty_wr_reg <= `MTU_RST16;
          per_act_reg <= `MTU_RST16;
          dty_act_reg <= `MTU_RST16;
        end else begin
          if (cap0) begin
            per_wr_reg <= cnt_reg;
            per_act_reg <= cnt_reg;
          end else begin
            if (wr_hs && wr_idx == idx_per && !lp) per_wr_reg <= f_merge(per_wr_reg, wd, ws);
            if (ld_lo) per_act_reg[7:0] <= per_wr_reg[7:0];
            if (ld_hi) per_act_reg[15:8] <= per_wr_reg[15:8];
          end
          if (cap1) begin
            dty_wr_reg <= cnt_reg;
            dty_act_reg <= cnt_reg;
          end else begin
            if (wr_hs && wr_idx == idx_dty && !lp) dty_wr_reg <= f_merge(dty_wr_reg, wd, ws);
            if (ld_lo) dty_act_reg[7:0] <= dty_wr_reg[7:0];
            if (ld_hi) dty_act_reg[15:8] <= dty_wr_reg[15:8];
          end
        end
      end

      // State 0 is default level, 1 is opposite level
      always @(posedge aclk) begin
        if (!aresetn) begin
          state_reg <= 2'b00;
        end else begin
          if (!run_lo || capm) begin
            state_reg[0] <= 1'b0;
          end else if (tick_lo) begin
            if (c0_zero || c0_dm) state_reg[0] <= 1'b0;
            else if (c0_up) state_reg[0] <= 1'b1;
          end
          if (!run_hi) begin
            state_reg[1] <= 1'b0;
          end else if (tick_hi) begin
            if (c1_zero || hi_dm) state_reg[1] <= 1'b0;
            else if (c1_up) state_reg[1] <= 1'b1;
          end
        end
      end

      // Registered pins cost one cycle but keep them glitch free
      always @(posedge aclk) begin
        if (!aresetn) begin
          pin_reg <= 2'b00;
          oe_n_reg <= 2'b11;
        end else begin
          // both pins follow one waveform in 16-bit mode
          pin_reg[0] <= pctl[3] ^ state_reg[0];
          pin_reg[1] <= pctl[7] ^ (dual ? state_reg[1] : state_reg[0]);
          oe_n_reg <= {2{~(dual | wide)}};
        end
      end

      assign pend_set[4*gi] = dual ? (tick_lo & lo_dm) : wide ? (tick_lo & w_dm) : cap0;
      assign pend_set[4*gi+1] = dual ? (tick_lo & lo_pm) : wide ? (tick_lo & w_pm) : cap1;
      assign pend_set[4*gi+2] = dual ? (tick_hi & hi_dm) : ovf;
      assign pend_set[4*gi+3] = tick_hi & hi_pm;
      assign lp_nib[4*gi+3:4*gi] = {4{lp}};
      assign cnt_all[16*gi+15:16*gi] = cnt_reg;
      assign per_all[16*gi+15:16*gi] = per_wr_reg;
      assign dty_all[16*gi+15:16*gi] = dty_wr_reg;
      assign timer_pin_out[2*gi+1:2*gi] = pin_reg;
      assign timer_pin_oe_n[2*gi+1:2*gi] = oe_n_reg;
    end
  endgenerate

endmodule

// file: design/mtu_defines.vh
// Register indices, field codes and reset values for the multi_timer_unit
// Contract
// - Four subsystems, each with 8-bit prescaler, 16-bit counter, two 16-bit registers, two pins.
// - One interrupt request per subsystem from four pending bits gated by enables.
// - Dual 8-bit mode splits counter; each half has its own run bit.
// - Counter steps on prescaler match; period is (period+1) times (prescale+1) clocks.
// - Output starts at default; counter clears after period match; 00h to 01h flips.
// - Duty match returns output to default on the next increment.
// - Duty above period holds opposite level; duty zero holds default.
// - Period and duty are double buffered; new values load at period match or stop.
// - Period and duty reads return the last written value.
// - Counter writes accepted only while both run bits are clear.
// - Preset counter counts from written value; above period it rolls over at FFh; in 16-bit PWM mode it rolls over at FFFFh.
// - Stopping returns pin to default, holds counter, prescaler resets when both stop.
// - 16-bit PWM mode joins both counter bytes, run by lower run bit only.
// - 16-bit PWM drives both pins, each with its own polarity.
// - Capture mode copies counter to period or duty register on pin event.
// - Lower run bit starts counter, prescaler and capture inputs in capture mode.
// - Per-pin edge selection; capture may also reset counter and prescaler.
// - Low-power mode freezes counter and prescaler; control registers stay writable.
// - Low-power mode ignores counter, period, duty writes and pending clears.
// - Dual 8-bit pending: low duty, low period, high duty, high period matches.
// - 16-bit pending: duty, period; capture pending: two captures and overflow.
// - Debug halt stops counting and captures; resumes from held values.
// - Two-bit mode field: low-power, dual 8-bit, 16-bit PWM, capture.
// - Three-bit edge select: single edge with optional reset, or both edges.
// - Pending bits set by hardware, cleared by writing one.
// - Pending bits set regardless of enable; enable only gates the request.
`ifndef MTU_DEFINES_VH
`define MTU_DEFINES_VH

// ----------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------
`define MTU_IDX_MODE 10'h080
`define MTU_IDX_PCTL1 10'h082
`define MTU_IDX_PCTL2 10'h084
`define MTU_IDX_IRQEN 10'h086
`define MTU_IDX_PEND 10'h088
`define MTU_IDX_PSC1 10'h08A
`define MTU_IDX_PSC2 10'h098
`define MTU_IDX_CNT1 10'h08C
`define MTU_IDX_PER1 10'h08E
`define MTU_IDX_DTY1 10'h090
`define MTU_IDX_CNT2 10'h092
`define MTU_IDX_PER2 10'h094
`define MTU_IDX_DTY2 10'h096
`define MTU_IDX_CNT3 10'h09A
`define MTU_IDX_PER3 10'h09C
`define MTU_IDX_DTY3 10'h09E
`define MTU_IDX_CNT4 10'h0A0
`define MTU_IDX_PER4 10'h0A2
`define MTU_IDX_DTY4 10'h0A4

// ----------------------------------------
// Field codes and reset values
// ----------------------------------------
`define MTU_MODE_LP 2'h0
`define MTU_MODE_DUAL8 2'h1
`define MTU_MODE_PWM16 2'h2
`define MTU_MODE_CAP 2'h3
`define MTU_RST16 16'h0000
`define MTU_RST8 8'h00
`define MTU_CNT_MAX 16'hFFFF
`define MTU_RESP_OKAY 2'h0
`define MTU_RESP_SLVERR 2'h2

`endif

// file: design/mtu_pin_sync.v
// Three-stage pin synchroniser with edge pulses
module mtu_pin_sync #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Pins and edges
  input wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] rise,
  output wire [WIDTH-1:0] fall
);

  reg [WIDTH-1:0] s1_reg;
  reg [WIDTH-1:0] s2_reg;
  reg [WIDTH-1:0] s3_reg;
  reg [WIDTH-1:0] lvl_reg;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_reg <= {WIDTH{1'b0}};
      s2_reg <= {WIDTH{1'b0}};
      s3_reg <= {WIDTH{1'b0}};
      lvl_reg <= {WIDTH{1'b0}};
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // Level accepted once stages two and three agree
      lvl_reg <= (s2_reg & s3_reg) | (lvl_reg & (s2_reg | s3_reg));
    end
  end

  // One-cycle glitches never reach the capture logic
  assign rise = s2_reg & s3_reg & ~lvl_reg;
  assign fall = ~s2_reg & ~s3_reg & lvl_reg;

endmodule

// file: bench/mtu_top_sva.sv
// Port checker for the multi timer unit
`include "mtu_defines.vh"
module mtu_top_sva #(
  parameter ADDR_W = 12
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Write side
  input wire [ADDR_W-1:0] awaddr,
  input wire awvalid,
  input wire awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wready,
  input wire [1:0] bresp,
  input wire bvalid,
  input wire bready,
  // Read side
  input wire [ADDR_W-1:0] araddr,
  input wire arvalid,
  input wire arready,
  input wire [31:0] rdata,
  input wire [1:0] rresp,
  input wire rvalid,
  input wire rready,
  // Requests
  input wire [3:0] irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // Enable shadow, so gating is judged from bus traffic only
  logic [15:0] en_reg;
  wire [3:0] en_any = {|en_reg[15:12], |en_reg[11:8], |en_reg[7:4], |en_reg[3:0]};
  always @(posedge aclk) begin
    if (!aresetn) begin
      en_reg <= 16'h0000;
    end else if (awvalid && awready && awaddr[11:2] == `MTU_IDX_IRQEN) begin
      if (wstrb[0]) en_reg[7:0] <= wdata[7:0];
      if (wstrb[1]) en_reg[15:8] <= wdata[15:8];
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_wr_blocked: assert property (bvalid |-> !awready && !wready)
    else $error("write taken during response");
  chk_wr_unmapped: assert property (awvalid && awready && awaddr[11:10] != 2'h0 |=>
    bvalid && bresp == `MTU_RESP_SLVERR) else $error("unmapped write not refused");
  chk_bresp_held: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  chk_rd_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered");
  chk_rdata_held: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data dropped");
  chk_rd_upper: assert property (rvalid |-> rdata[31:16] == 16'h0000 && !arready)
    else $error("read upper half or ready wrong");
  chk_rd_unmapped: assert property (arvalid && arready && araddr[11:10] != 2'h0 |=>
    rresp == `MTU_RESP_SLVERR && rdata == 32'h00000000) else $error("unmapped read not refused");
  chk_irq_gated: assert property ((irq & ~(en_any | $past(en_any))) == 4'h0)
    else $error("request without enable");
  cov_write: cover property (awvalid && awready);
  cov_read: cover property (arvalid && arready);
  cov_irq: cover property ($rose(irq[0]));
endmodule

bind mtu_top mtu_top_sva #(.ADDR_W(ADDR_W)) i_mtu_top_sva (.aclk, .aresetn, .awaddr, .awvalid, .awready,
  .wdata, .wstrb, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
  .rready, .irq);

// file: bench/mtu_pin_src.sv
// External signal source pulsing one capture pin
module mtu_pin_src (
  // Clock
  input wire aclk,
  // Pulse request
  input wire go,
  input wire [2:0] sel,
  input wire [7:0] width,
  // Pin levels, idle low between pulses
  output logic [7:0] level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_reg = 8'h00;
  logic [2:0] sel_reg = 3'h0;
  always @(posedge aclk) begin
    if (go) begin
      cnt_reg <= width;
      sel_reg <= sel;
    end else if (cnt_reg != 8'h00) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end
  assign level = (cnt_reg != 8'h00) ? (8'h01 << sel_reg) : 8'h00;
endmodule

// file: bench/tb_mtu_top.sv
// Self-checking bench for the multi timer unit
`include "mtu_defines.vh"
module tb_mtu_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_MODE = {`MTU_IDX_MODE, 2'b00};
  localparam logic [11:0] A_PCTL1 = {`MTU_IDX_PCTL1, 2'b00};
  localparam logic [11:0] A_IRQEN = {`MTU_IDX_IRQEN, 2'b00};
  localparam logic [11:0] A_PEND = {`MTU_IDX_PEND, 2'b00};
  localparam logic [11:0] A_PSC1 = {`MTU_IDX_PSC1, 2'b00};
  localparam logic [11:0] A_CNT1 = {`MTU_IDX_CNT1, 2'b00};
  localparam logic [11:0] A_PER1 = {`MTU_IDX_PER1, 2'b00};
  localparam logic [11:0] A_DTY1 = {`MTU_IDX_DTY1, 2'b00};
  localparam logic [11:0] A_PER2 = {`MTU_IDX_PER2, 2'b00};
  localparam logic [11:0] A_DTY2 = {`MTU_IDX_DTY2, 2'b00};
  localparam logic [11:0] A_CNT3 = {`MTU_IDX_CNT3, 2'b00};
  localparam logic [11:0] A_PER3 = {`MTU_IDX_PER3, 2'b00};
  localparam logic [11:0] A_DTY3 = {`MTU_IDX_DTY3, 2'b00};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, debug_halt = 1'b0, go = 1'b0;
  logic [2:0] sel = 3'h0;
  logic [3:0] wstrb = 4'hF;
  logic bready = 1'b1, rready = 1'b1;
  logic [1:0] last_resp;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] pin_in, pin_out, oe_n, src_level;
  wire [3:0] irq;
  int error_cnt = 0;
  int checks_done = 0;
  always #4 aclk = ~aclk;
  // Pin level: the design wins where it drives, else the source
  assign pin_in = (~oe_n & pin_out) | (oe_n & src_level);
  mtu_top i_mtu_top (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .timer_pin_in(pin_in),
    .timer_pin_out(pin_out), .timer_pin_oe_n(oe_n), .debug_halt, .irq);
  mtu_pin_src i_mtu_pin_src (.aclk, .go, .sel, .width(8'h03), .level(src_level));
  // ----------------------------------------
  // Bus, pin pulse and compare tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b0;
    do @(posedge aclk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    @(posedge aclk);
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    last_resp = bresp;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b0;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    @(posedge aclk);
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    last_resp = rresp;
    @(posedge aclk);
  endtask
  task automatic pulse(input logic [2:0] s);
    go <= 1'b1;
    sel <= s;
    @(posedge aclk);
    go <= 1'b0;
  endtask
  task automatic pulse_len(input int p, output int hi, output int lo);
    hi = 0;
    lo = 0;
    while (pin_out[p] !== 1'b0) @(posedge aclk);
    while (pin_out[p] !== 1'b1) @(posedge aclk);
    while (pin_out[p] === 1'b1) begin
      hi++;
      @(posedge aclk);
    end
    while (pin_out[p] === 1'b0) begin
      lo++;
      @(posedge aclk);
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_bus;
    logic [31:0] d;
    chk({24'h0, oe_n}, 32'hFF, "pins released");
    rd(A_MODE, d);
    chk(d, 32'h0, "mode reset");
    wr(A_IRQEN, 16'h0101);
    rd(A_IRQEN, d);
    chk(d, 32'h0101, "enable in low power");
    wr(A_PER1, 16'h0055);
    rd(A_PER1, d);
    chk(d, 32'h0, "period in low power");
    wr(12'hC00, 16'h1111);
    chk({30'h0, last_resp}, {30'h0, `MTU_RESP_SLVERR}, "unmapped write");
    rd(12'hC00, d);
    chk({30'h0, last_resp}, {30'h0, `MTU_RESP_SLVERR}, "unmapped read");
    $display("test reset_bus done");
  endtask
  task automatic t_dual8;
    logic [31:0] d;
    int hi, lo;
    wr(A_MODE, 16'h0004);
    wr(A_PSC1, 16'h0001);
    wr(A_PER1, 16'h0405);
    wr(A_DTY1, 16'h0002);
    wr(A_MODE, 16'h0007);
    pulse_len(0, hi, lo);
    chk(hi, 4, "high time");
    chk(lo, 8, "low time");
    chk(pin_out[1], 1'b0, "zero duty pin");
    rd(A_PEND, d);
    chk(d & 32'h000B, 32'h000B, "dual pending");
    chk(irq[0], 1'b1, "request raised");
    wr(A_CNT1, 16'h0077);
    rd(A_CNT1, d);
    chk(d[7:0] <= 8'h05, 1'b1, "counter write ignored");
    wr(A_PER1, 16'h0409);
    rd(A_PER1, d);
    chk(d, 32'h0409, "written period read");
    pulse_len(0, hi, lo);
    pulse_len(0, hi, lo);
    chk(lo, 16, "low time after reload");
    wr(A_MODE, 16'h0004);
    repeat (4) @(posedge aclk);
    chk(pin_out[0], 1'b0, "stopped pin default");
    wr(A_PEND, 16'h000F);
    rd(A_PEND, d);
    chk(d & 32'h000F, 32'h0, "pending cleared");
    chk(irq[0], 1'b0, "request dropped");
    $display("test dual8 done");
  endtask
  task automatic t_pwm16;
    logic [31:0] d;
    wr(A_MODE, 16'h0080);
    wr(A_PCTL1, 16'h8000);
    wr(A_PER2, 16'h0004);
    wr(A_DTY2, 16'h0005);
    wr(A_MODE, 16'h0090);
    repeat (20) @(posedge aclk);
    chk(pin_out[3:2], 2'b01, "full duty pair");
    chk(oe_n[3:2], 2'b00, "pins driven");
    wr(A_DTY2, 16'h0000);
    repeat (20) @(posedge aclk);
    chk(pin_out[3:2], 2'b10, "zero duty pair");
    rd(A_PEND, d);
    chk(d[5], 1'b1, "period pending");
    wr(A_MODE, 16'h0000);
    $display("test pwm16 done");
  endtask
  task automatic t_capture;
    logic [31:0] d, e, p;
    wr(A_MODE, 16'h0D00);
    pulse(3'h4);
    repeat (39) @(posedge aclk);
    pulse(3'h5);
    repeat (10) @(posedge aclk);
    rd(A_PER3, p);
    rd(A_DTY3, e);
    chk(e - p, 32'd40, "capture spacing");
    rd(A_PEND, d);
    chk(d & 32'h0F00, 32'h0300, "capture pending");
    chk(irq[2], 1'b1, "capture request");
    debug_halt <= 1'b1;
    rd(A_CNT3, d);
    pulse(3'h4);
    repeat (10) @(posedge aclk);
    rd(A_CNT3, e);
    chk(e, d, "halted counter");
    rd(A_PER3, e);
    chk(e, p, "halted capture");
    debug_halt <= 1'b0;
    wr(A_PEND, 16'h0100);
    rd(A_PEND, d);
    chk(d & 32'h0F00, 32'h0200, "one pending cleared");
    chk(irq[2], 1'b0, "disabled source silent");
    wr(A_MODE, 16'h0000);
    wr(A_PEND, 16'h0200);
    rd(A_PEND, d);
    chk(d & 32'h0F00, 32'h0200, "low power keeps pending");
    $display("test capture done");
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog sized well above the longest expected run
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    stop_test();
  end
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset_bus();
    t_dual8();
    t_pwm16();
    t_capture();
    stop_test();
  end
endmodule
